/* File: rtl/qlo_pkg.sv */
// Purpose: Shared constants and types for the quadrature LO and phase select block
// Assumes: Single 100 MHz system clock; all pins sampled into it
// Notes: Serial port frames are MSB first only
package qlo_pkg;

  // ==========================================================
  // Register map
  localparam logic [12:0] QLO_ADDR_CHAN_SEL = 13'h0005;
  localparam logic [12:0] QLO_ADDR_PHASE = 13'h002d;
  localparam logic [12:0] QLO_ADDR_DIV_STAT = 13'h002e;
  localparam logic [7:0] QLO_CHAN_SEL_RST = 8'hff;
  localparam logic [3:0] QLO_PHASE_RST = 4'h0;
  localparam int QLO_PHASE_LSB = 0;
  localparam int QLO_PHASE_W = 4;
  localparam int QLO_NUM_CHAN = 8;

  // ==========================================================
  // Instruction word layout
  localparam int QLO_INSTR_RD_BIT = 15;
  localparam int QLO_INSTR_LEN_MSB = 14;
  localparam int QLO_INSTR_LEN_LSB = 13;
  localparam logic [1:0] QLO_LEN_STREAM = 2'h3;
  localparam logic [4:0] QLO_INSTR_BITS = 5'h10;
  localparam logic [3:0] QLO_BYTE_BITS = 4'h8;

  // ==========================================================
  // Divider
  localparam logic [1:0] QLO_DIV_RST_CNT = 2'h0;
  localparam logic QLO_LO_I_RST = 1'b1;
  localparam logic QLO_LO_Q_RST = 1'b0;

  // ==========================================================
  // Types
  typedef struct packed {
    logic sclk;
    logic csb;
    logic sdio;
  } qlo_spi_in_s;

  typedef struct packed {
    logic lo_i;
    logic lo_q;
  } qlo_lo_s;

  typedef enum logic [1:0] {
    QLO_SPI_IDLE = 2'b00,
    QLO_SPI_INSTR = 2'b01,
    QLO_SPI_DATA = 2'b10
  } qlo_spi_e;

endpackage : qlo_pkg

/* File: rtl/qlo_lo_divider.sv */
// Purpose: Divide-by-four quadrature LO generator
// Assumes: lo_edge is a one-cycle pulse per rising edge of the four-times-LO clock
// Notes: Reset input already synchronised by the caller
`timescale 1ns/100ps
`default_nettype none
module qlo_lo_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Divider control
  input wire logic lo_edge,
  input wire logic div_reset,
  // Outputs
  output var qlo_pkg::qlo_lo_s lo,
  output logic [1:0] count
);
  import qlo_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  qlo_lo_s lo_r;

  assign cnt_nxt = cnt_r + 2'h1;

  // ==========================================================
  // Counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= QLO_DIV_RST_CNT;
    end else if (ce) begin
      if (div_reset) begin
        cnt_r <= QLO_DIV_RST_CNT;
      end else if (lo_edge) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // ==========================================================
  // Output retiming
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_r.lo_i <= QLO_LO_I_RST;
      lo_r.lo_q <= QLO_LO_Q_RST;
    end else if (ce) begin
      if (div_reset) begin
        lo_r.lo_i <= QLO_LO_I_RST;
        lo_r.lo_q <= QLO_LO_Q_RST;
      end else if (lo_edge) begin
        lo_r.lo_i <= ~cnt_nxt[1];
        lo_r.lo_q <= cnt_nxt[1] ^ cnt_nxt[0];
      end
    end
  end

  assign lo = lo_r;
  assign count = cnt_r;

endmodule : qlo_lo_divider
`default_nettype wire

/* File: rtl/qlo_phase_select.sv */
// Purpose: Quadrature LO generation and per-channel phase code registers behind a serial port
// Assumes: All pins asynchronous to clk, well below clk rate
// Notes: Serial port is MSB first, address decrements per data byte
`timescale 1ns/100ps
`default_nettype none
module qlo_phase_select (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // LO pins
  input wire logic lo_times_four_clock,
  input wire logic lo_reset,
  // Serial port pins
  input wire qlo_pkg::qlo_spi_in_s spi_in,
  output logic sdio_out,
  output logic sdio_oe,
  // LO and phase outputs
  output var qlo_pkg::qlo_lo_s lo,
  output logic [qlo_pkg::QLO_NUM_CHAN*qlo_pkg::QLO_PHASE_W-1:0] chan_phase_code
);
  import qlo_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic lo_clk_d_r;
  logic sclk_d_r;
  logic lo_edge;
  logic sclk_rise;
  logic sclk_fall;
  logic csb_s;
  logic sdio_s;
  logic rst_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 5'h03;
      sync2_r <= 5'h03;
      lo_clk_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= {lo_times_four_clock, lo_reset, spi_in.sclk, spi_in.csb, spi_in.sdio};
      sync2_r <= sync1_r;
      lo_clk_d_r <= sync2_r[4];
      sclk_d_r <= sync2_r[2];
    end
  end

  assign rst_s = sync2_r[3];
  assign csb_s = sync2_r[1];
  assign sdio_s = sync2_r[0];
  assign lo_edge = sync2_r[4] & ~lo_clk_d_r;
  assign sclk_rise = sync2_r[2] & ~sclk_d_r;
  assign sclk_fall = ~sync2_r[2] & sclk_d_r;

  // ==========================================================
  // Divider
  logic [1:0] div_count;

  qlo_lo_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .lo_edge(lo_edge),
    .div_reset(rst_s),
    .lo(lo),
    .count(div_count)
  );

  // ==========================================================
  // Serial port state
  qlo_spi_e state_r;
  logic [15:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic rd_r;
  logic [1:0] len_r;
  logic [1:0] byte_cnt_r;
  logic [12:0] addr_r;
  logic [7:0] tx_r;
  logic oe_r;
  logic [15:0] shift_nxt;
  logic [7:0] rd_data;
  logic byte_done;
  logic instr_done;
  logic last_byte;

  assign shift_nxt = {shift_r[14:0], sdio_s};
  assign instr_done = (state_r == QLO_SPI_INSTR) && sclk_rise && (bit_cnt_r == QLO_INSTR_BITS - 5'h1);
  assign byte_done = (state_r == QLO_SPI_DATA) && sclk_rise && (bit_cnt_r[3:0] == QLO_BYTE_BITS - 4'h1);
  assign last_byte = (len_r != QLO_LEN_STREAM) && (byte_cnt_r == len_r);

  // ==========================================================
  // Registers
  logic [7:0] chan_sel_r;
  logic [QLO_PHASE_W-1:0] code_r [QLO_NUM_CHAN];
  logic [QLO_PHASE_W-1:0] first_code;

  always_comb begin
    first_code = code_r[0];
    for (int k = QLO_NUM_CHAN - 1; k >= 0; k--) begin
      if (chan_sel_r[k]) begin
        first_code = code_r[k];
      end
    end
  end

  always_comb begin
    if (addr_r == QLO_ADDR_CHAN_SEL) begin
      rd_data = chan_sel_r;
    end else if (addr_r == QLO_ADDR_PHASE) begin
      rd_data = {4'h0, first_code};
    end else if (addr_r == QLO_ADDR_DIV_STAT) begin
      rd_data = {5'h00, rst_s, div_count};
    end else begin
      rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel_r <= QLO_CHAN_SEL_RST;
    end else if (ce) begin
      if (byte_done && !rd_r && addr_r == QLO_ADDR_CHAN_SEL) begin
        chan_sel_r <= shift_nxt[7:0];
      end
    end
  end

  generate
    for (genvar g = 0; g < QLO_NUM_CHAN; g++) begin : g_chan
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          code_r[g] <= QLO_PHASE_RST;
        end else if (ce) begin
          if (byte_done && !rd_r && addr_r == QLO_ADDR_PHASE && chan_sel_r[g]) begin
            code_r[g] <= shift_nxt[QLO_PHASE_LSB +: QLO_PHASE_W];
          end
        end
      end
      assign chan_phase_code[g*QLO_PHASE_W +: QLO_PHASE_W] = code_r[g];
    end
  endgenerate

  // ==========================================================
  // Frame sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= QLO_SPI_IDLE;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      rd_r <= 1'b0;
      len_r <= 2'h0;
      byte_cnt_r <= 2'h0;
      addr_r <= 13'h0000;
    end else if (ce) begin
      if (csb_s) begin
        // Stall between bytes keeps a fixed-length frame, otherwise (streaming or mid-byte) abort
        if (!(state_r == QLO_SPI_DATA && bit_cnt_r == 5'h00 && len_r != QLO_LEN_STREAM)) begin
          state_r <= QLO_SPI_IDLE;
        end
        bit_cnt_r <= 5'h00;
      end else begin
        case (state_r)
          QLO_SPI_IDLE: begin
            state_r <= QLO_SPI_INSTR;
            bit_cnt_r <= 5'h00;
          end
          QLO_SPI_INSTR: begin
            if (sclk_rise) begin
              shift_r <= shift_nxt;
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (instr_done) begin
              rd_r <= shift_nxt[QLO_INSTR_RD_BIT];
              len_r <= shift_nxt[QLO_INSTR_LEN_MSB:QLO_INSTR_LEN_LSB];
              addr_r <= shift_nxt[12:0];
              byte_cnt_r <= 2'h0;
              bit_cnt_r <= 5'h00;
              state_r <= QLO_SPI_DATA;
            end
          end
          QLO_SPI_DATA: begin
            if (sclk_rise) begin
              shift_r <= shift_nxt;
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (byte_done) begin
              bit_cnt_r <= 5'h00;
              addr_r <= addr_r - 13'h0001;
              byte_cnt_r <= byte_cnt_r + 2'h1;
              if (last_byte) begin
                state_r <= QLO_SPI_IDLE;
              end
            end
          end
          default: begin
            state_r <= QLO_SPI_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Readback driver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
      oe_r <= 1'b0;
    end else if (ce) begin
      if (csb_s || state_r != QLO_SPI_DATA || !rd_r) begin
        oe_r <= 1'b0;
      end else if (sclk_fall) begin
        oe_r <= 1'b1;
        if (bit_cnt_r == 5'h00) begin
          tx_r <= rd_data;
        end else begin
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  assign sdio_out = tx_r[7];
  assign sdio_oe = oe_r;

endmodule : qlo_phase_select
`default_nettype wire

/* File: verif/qlo_lo_src.sv */
// Purpose: LO source and array reset model
// Assumes: Pins driven just after clk rise
// Notes: LO clock stands low between bursts
`timescale 1ns/100ps
`default_nettype none
module qlo_lo_src (
  // Clock
  input wire logic clk,
  // LO pins
  output logic lo_times_four_clock,
  output logic lo_reset
);
  // ==========
  // Pin drive
  initial begin
    lo_times_four_clock = 1'b0;
    lo_reset = 1'b0;
  end
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk) lo_times_four_clock <= 1'b1;
      repeat (4) @(posedge clk);
      lo_times_four_clock <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : edges
  task automatic pulse;
    @(posedge clk) lo_reset <= 1'b1;
    repeat (6) @(posedge clk);
    lo_reset <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic level(input logic v);
    @(posedge clk) lo_reset <= v;
    repeat (6) @(posedge clk);
  endtask : level
endmodule : qlo_lo_src
`default_nettype wire

/* File: verif/qlo_sva.sv */
// Purpose: Port checks for the LO block
// Assumes: Sees top ports only
// Notes: Bound at foot
`timescale 1ns/100ps
`default_nettype none
module qlo_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pins
  input wire logic lo_times_four_clock,
  input wire logic lo_reset,
  input wire qlo_pkg::qlo_spi_in_s spi_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire qlo_pkg::qlo_lo_s lo,
  input wire logic [qlo_pkg::QLO_NUM_CHAN*qlo_pkg::QLO_PHASE_W-1:0] chan_phase_code
);
  import qlo_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Checks
  property p_seq; $changed(lo) |-> lo == {~$past(lo.lo_q), $past(lo.lo_i)} || lo == 2'b10; endproperty
  a_seq: assert property (p_seq) else $error("bad LO step");
  property p_one; $changed(lo.lo_i) |-> $stable(lo.lo_q) || lo_reset; endproperty
  a_one: assert property (p_one) else $error("I and Q moved together");
  property p_step; $rose(lo_times_four_clock) && ce && !lo_reset |-> ##[1:6] $changed(lo); endproperty
  a_step: assert property (p_step) else $error("edge not taken");
  property p_rst; (lo_reset && ce) [*5] |=> lo == 2'b10; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_por; $rose(rst_n) |-> lo == 2'b10 && chan_phase_code == '0 && !sdio_oe; endproperty
  a_por: assert property (p_por) else $error("bad reset values");
  property p_csb; $changed(chan_phase_code) |-> !$past(spi_in.csb, 3); endproperty
  a_csb: assert property (p_csb) else $error("code moved outside frame");
  property p_div; $changed(chan_phase_code) |-> $stable(lo); endproperty
  a_div: assert property (p_div) else $error("write moved LO");
  property p_oe; spi_in.csb [*5] |-> !sdio_oe; endproperty
  a_oe: assert property (p_oe) else $error("drives when deselected");
endmodule : qlo_sva
bind qlo_phase_select qlo_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce),
  .lo_times_four_clock(lo_times_four_clock), .lo_reset(lo_reset), .spi_in(spi_in),
  .sdio_out(sdio_out), .sdio_oe(sdio_oe), .lo(lo), .chan_phase_code(chan_phase_code));
`default_nettype wire

/* File: verif/tb_quadrature_lo_phase_select.sv */
// Purpose: Bench for the LO block
// Assumes: Serial frames MSB first
// Notes: Pin pulled low when idle
`timescale 1ns/100ps
`default_nettype none
module tb_quadrature_lo_phase_select;
  import qlo_pkg::*;
  logic clk, rst_n, ce, sclk, csb, m_sdio, m_oe, sdio_out, sdio_oe, l4, lrst, pin;
  qlo_lo_s lo;
  qlo_spi_in_s spi_in;
  logic [31:0] code, exp_code;
  logic [7:0] q;
  int fails, checks;
  // ==========
  // Harness
  assign pin = sdio_oe ? sdio_out : (m_oe ? m_sdio : 1'b0);
  assign spi_in = {sclk, csb, pin};
  qlo_lo_src u_src (.clk(clk), .lo_times_four_clock(l4), .lo_reset(lrst));
  qlo_phase_select u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .lo_times_four_clock(l4),
    .lo_reset(lrst), .spi_in(spi_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .lo(lo),
    .chan_phase_code(code));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic rw, input logic [1:0] len, input logic [12:0] a, input logic [15:0] d,
    input int nb, output logic [15:0] rd);
    logic [31:0] f;
    f = {rw, len, a, d};
    @(posedge clk) csb <= 1'b0;
    for (int i = 31; i >= 16 - 8 * nb; i--) begin
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
      m_sdio <= f[i];
      m_oe <= !(rw && i < 16);
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      rd = {rd[14:0], pin};
    end
    repeat (8) @(posedge clk);
    csb <= 1'b1;
    m_oe <= 1'b0;
    repeat (6) @(posedge clk);
    sclk <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : xfer
  task automatic acc(input logic rw, input logic [12:0] a, input logic [7:0] d,
    output logic [7:0] rd);
    logic [15:0] r;
    xfer(rw, 2'h0, a, {d, 8'h00}, 1, r);
    rd = r[7:0];
  endtask : acc
  // ==========
  // Scenarios
  task automatic t_reset;
    chk("lo", lo, 32'h2);
    chk("codes", code, 32'h0);
    acc(1'b1, QLO_ADDR_CHAN_SEL, 8'h00, q);
    chk("sel", q, QLO_CHAN_SEL_RST);
    acc(1'b1, 13'h007f, 8'h00, q);
    chk("unmapped", q, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_div;
    logic [1:0] e;
    e = 2'b10;
    for (int i = 0; i < 8; i++) begin
      u_src.edges(1);
      e = {~e[0], e[1]};
      chk("lo step", lo, e);
    end
    ce <= 1'b0;
    u_src.edges(1);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk("lo frozen", lo, e);
    $display("t_div done");
  endtask : t_div
  task automatic t_rst;
    u_src.edges(2);
    chk("lo pre", lo, 32'h1);
    acc(1'b1, QLO_ADDR_DIV_STAT, 8'h00, q);
    chk("stat cnt", q, 32'h2);
    u_src.pulse();
    chk("lo reset", lo, 32'h2);
    u_src.edges(1);
    chk("lo resume", lo, 32'h3);
    u_src.level(1'b1);
    u_src.edges(1);
    chk("lo held", lo, 32'h2);
    acc(1'b1, QLO_ADDR_DIV_STAT, 8'h00, q);
    chk("stat rst", q, 32'h4);
    u_src.level(1'b0);
    u_src.edges(1);
    chk("lo again", lo, 32'h3);
    $display("t_rst done");
  endtask : t_rst
  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      acc(1'b0, QLO_ADDR_CHAN_SEL, 8'h01 << c[2:0], q);
      acc(1'b0, QLO_ADDR_PHASE, {4'hf, c[3:0]}, q);
      exp_code[4*c[2:0] +: 4] = c[3:0];
      chk("code", code, exp_code);
      acc(1'b1, QLO_ADDR_PHASE, 8'h00, q);
      chk("code rd", q, {4'h0, c[3:0]});
    end
    chk("lo kept", lo, 32'h3);
    acc(1'b0, QLO_ADDR_CHAN_SEL, 8'hff, q);
    acc(1'b0, QLO_ADDR_PHASE, 8'h03, q);
    chk("same", code, 32'h33333333);
    acc(1'b0, QLO_ADDR_CHAN_SEL, 8'h02, q);
    acc(1'b0, QLO_ADDR_PHASE, 8'h04, q);
    acc(1'b0, 13'h007f, 8'h55, q);
    chk("step", code, 32'h33333343);
    $display("t_codes done");
  endtask : t_codes
  task automatic t_multi;
    logic [15:0] r;
    xfer(1'b1, 2'h1, QLO_ADDR_DIV_STAT, 16'h0000, 2, r);
    chk("pair rd", r, 32'h0104);
    xfer(1'b0, 2'h1, QLO_ADDR_DIV_STAT, 16'hff09, 2, r);
    chk("pair wr", code, 32'h33333393);
    xfer(1'b0, QLO_LEN_STREAM, QLO_ADDR_PHASE, 16'h0a55, 2, r);
    chk("stream", code, 32'h333333a3);
    chk("lo idle", lo, 32'h3);
    $display("t_multi done");
  endtask : t_multi
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    sclk = 1'b0;
    csb = 1'b1;
    m_sdio = 1'b0;
    m_oe = 1'b0;
    fails = 0;
    checks = 0;
    exp_code = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_div();
    t_rst();
    t_codes();
    t_multi();
    print_verdict();
  end
endmodule : tb_quadrature_lo_phase_select
`default_nettype wire
